// *** hdl/origin_return_sequencer.sv ***
// origin-return sequencer for one axis, registers on classic wishbone
`timescale 1ns/10ps
module origin_return_sequencer #(
  parameter int TICK_CYCLES = origin_pkg::TICK_CYCLES
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire origin_pkg::wb_req_type wb_req_i,
  output origin_pkg::wb_rsp_type      wb_rsp_o,
  input  wire logic                   dog_i,
  input  wire logic                   zero_i,
  input  wire logic                   stop_i,
  input  wire logic                   limit_upper_i,
  input  wire logic                   limit_lower_i,
  output logic                        pulse_o,
  output logic                        dir_o,
  output logic                        clear_o,
  output logic                        torque_limit_o
);
  import origin_pkg::*;

  typedef struct packed {
    seq_state_type st;
    logic [7:0]    cfg;
    logic [31:0]   fast;
    logic [31:0]   creep;
    logic [15:0]   dwell;
    logic [15:0]   clrw;
    logic [31:0]   accel;
    logic [31:0]   origin;
    logic [31:0]   cur_feed;
    logic [31:0]   mach_feed;
    logic [15:0]   err;
    logic [15:0]   pend;
    logic          request;
    logic          complete;
    logic          by_stop;
    logic          zero_q;
    logic          torque;
    logic          ack;
    logic [31:0]   dat;
    logic [31:0]   div;
    logic          tick;
  } seq_type;

  seq_type s;
  seq_type next_s;

  logic        bus_req;
  logic        bus_write;
  logic        start_cmd;
  logic        stop_cmd;
  logic        restart_cmd;
  logic        err_clr;
  logic [15:0] new_err;
  logic        stopper;
  logic        limit_hit;
  logic [31:0] target;
  logic [31:0] step;
  logic        halt;
  logic        dwell_load;
  logic        dwell_done;
  logic        clr_load;
  logic        clr_run;
  logic        clr_done;
  logic [31:0] speed;
  logic        at_target;
  logic        ramp_pulse;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] read_mux(input seq_type v,
                                           input logic [7:0] adr);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (adr)
      OFS_CFG:       r = {24'h00_0000, v.cfg};
      OFS_FAST:      r = v.fast;
      OFS_CREEP:     r = v.creep;
      OFS_DWELL:     r = {16'h0000, v.dwell};
      OFS_CLRW:      r = {16'h0000, v.clrw};
      OFS_ORIGIN:    r = v.origin;
      OFS_ERROR:     r = {16'h0000, v.err};
      OFS_CUR_FEED:  r = v.cur_feed;
      OFS_MACH_FEED: r = v.mach_feed;
      OFS_ACCEL:     r = v.accel;
      OFS_STATUS: begin
        r[STAT_BUSY] = (v.st != ST_IDLE);
        r[STAT_ERROR] = (v.err != ERR_NONE);
        r[STAT_REQUEST] = v.request;
        r[STAT_COMPLETE] = v.complete;
      end
      default:       r = 32'h0000_0000;
    endcase
    return r;
  endfunction : read_mux

  assign bus_req = wb_req_i.cyc & wb_req_i.stb;
  assign bus_write = bus_req & wb_req_i.we & s.ack;
  assign stopper = s.cfg[CFG_METHOD];
  assign limit_hit = s.cfg[CFG_DIR] ? limit_lower_i : limit_upper_i;
  assign step = 32'(s.accel[8*s.cfg[CFG_ACCEL_LO +: 2] +: 8]) << ACCEL_SHIFT;

  always_comb begin
    next_s = s;
    start_cmd = 1'b0;
    stop_cmd = stop_i;
    restart_cmd = 1'b0;
    err_clr = 1'b0;
    new_err = ERR_NONE;
    target = s.fast;
    halt = 1'b0;
    dwell_load = 1'b0;
    clr_load = 1'b0;

    // bus: ack one cycle after request, write lands on acked edge
    next_s.ack = bus_req & ~s.ack;
    if (bus_req & ~s.ack) begin
      next_s.dat = read_mux(s, wb_req_i.adr);
    end
    if (bus_write) begin
      unique case (wb_req_i.adr)
        OFS_CTRL: begin
          if (wb_req_i.sel[0]) begin
            start_cmd = wb_req_i.dat[CTRL_START];
            stop_cmd = stop_i | wb_req_i.dat[CTRL_STOP];
            restart_cmd = wb_req_i.dat[CTRL_RESTART];
            err_clr = wb_req_i.dat[CTRL_ERR_CLR];
          end
        end
        OFS_CFG: begin
          if (wb_req_i.sel[0]) begin
            next_s.cfg = wb_req_i.dat[7:0];
          end
        end
        OFS_FAST:   next_s.fast = merge(s.fast, wb_req_i.dat, wb_req_i.sel);
        OFS_CREEP:  next_s.creep = merge(s.creep, wb_req_i.dat, wb_req_i.sel);
        OFS_DWELL: begin
          next_s.dwell = 16'(merge({16'h0000, s.dwell}, wb_req_i.dat,
                                   wb_req_i.sel));
        end
        OFS_CLRW: begin
          next_s.clrw = 16'(merge({16'h0000, s.clrw}, wb_req_i.dat,
                                  wb_req_i.sel));
        end
        OFS_ORIGIN: begin
          next_s.origin = merge(s.origin, wb_req_i.dat, wb_req_i.sel);
        end
        OFS_ACCEL:  next_s.accel = merge(s.accel, wb_req_i.dat, wb_req_i.sel);
        default:    next_s.dat = next_s.dat;
      endcase
    end

    // millisecond tick for ramp and timers
    next_s.tick = 1'b0;
    if (s.div >= 32'(TICK_CYCLES - 1)) begin
      next_s.div = 32'h0000_0000;
      next_s.tick = 1'b1;
    end else begin
      next_s.div = s.div + 32'h0000_0001;
    end

    next_s.zero_q = zero_i;

    if (ramp_pulse) begin
      if (s.cfg[CFG_DIR]) begin
        next_s.cur_feed = s.cur_feed - 32'h0000_0001;
        next_s.mach_feed = s.mach_feed - 32'h0000_0001;
      end else begin
        next_s.cur_feed = s.cur_feed + 32'h0000_0001;
        next_s.mach_feed = s.mach_feed + 32'h0000_0001;
      end
    end

    unique case (s.st)
      ST_IDLE: begin
        halt = 1'b1;
        if (start_cmd) begin
          if (!stopper && s.complete && !s.cfg[CFG_RETRY]) begin
            new_err = ERR_START_AT_OP;
          end else if (limit_hit) begin
            new_err = ERR_LIMIT;
          end else begin
            next_s.complete = 1'b0;
            next_s.request = 1'b1;
            next_s.by_stop = 1'b0;
            next_s.pend = ERR_NONE;
            if (dog_i) begin
              next_s.st = ST_CREEP;
              dwell_load = stopper;
            end else begin
              next_s.st = ST_FAST;
            end
          end
        end else if (restart_cmd && s.by_stop) begin
          new_err = ERR_NO_RESTART;
        end
      end
      ST_FAST: begin
        target = s.fast;
        if (dog_i) begin
          next_s.st = ST_DECEL;
          dwell_load = stopper;
        end
      end
      ST_DECEL: begin
        target = s.creep;
        if (!stopper && !dog_i) begin
          next_s.st = ST_HALT;
          next_s.pend = ERR_DOG_TIMING;
        end else if (stopper && dwell_done) begin
          next_s.st = ST_HALT;
          next_s.pend = ERR_DWELL_FAULT;
        end else if (at_target) begin
          next_s.st = ST_CREEP;
        end
      end
      ST_CREEP: begin
        target = s.creep;
        if (stopper && dwell_done) begin
          halt = 1'b1;
          clr_load = 1'b1;
          next_s.st = ST_CLEAR;
        end else if (!stopper && !dog_i) begin
          next_s.st = ST_SEEK_ZERO;
        end
      end
      ST_SEEK_ZERO: begin
        target = s.creep;
        if (zero_i && !s.zero_q) begin
          halt = 1'b1;
          clr_load = 1'b1;
          next_s.st = ST_CLEAR;
        end
      end
      ST_HALT: begin
        target = 32'h0000_0000;
        if (speed == 32'h0000_0000) begin
          new_err = s.pend;
          next_s.st = ST_IDLE;
        end
      end
      ST_CLEAR: begin
        halt = 1'b1;
        if (clr_done) begin
          next_s.complete = 1'b1;
          next_s.request = 1'b0;
          next_s.cur_feed = s.origin;
          next_s.mach_feed = s.origin;
          next_s.st = ST_IDLE;
        end
      end
    endcase

    if (s.st inside {ST_FAST, ST_DECEL, ST_CREEP, ST_SEEK_ZERO}) begin
      if (limit_hit) begin
        halt = 1'b1;
        new_err = ERR_LIMIT;
        next_s.st = ST_IDLE;
      end else if (stop_cmd) begin
        next_s.by_stop = 1'b1;
        next_s.pend = ERR_NONE;
        next_s.st = ST_HALT;
      end
    end

    // a new error wins over a clear in the same cycle
    if (new_err != ERR_NONE) begin
      next_s.err = new_err;
    end else if (err_clr) begin
      next_s.err = ERR_NONE;
    end

    next_s.torque = stopper && (next_s.st == ST_CREEP);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.cfg <= RST_CFG;
      s.fast <= RST_FAST;
      s.creep <= RST_CREEP;
      s.dwell <= RST_DWELL;
      s.clrw <= RST_CLRW;
      s.accel <= RST_ACCEL;
      s.request <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  speed_ramp #(
    .W (32)
  ) u_ramp (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .tick_i      (s.tick),
    .halt_i      (halt),
    .target_i    (target),
    .step_i      (step),
    .speed_o     (speed),
    .at_target_o (at_target),
    .pulse_o     (ramp_pulse)
  );

  ms_timer #(
    .W (16)
  ) u_dwell (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (s.tick),
    .load_i (dwell_load),
    .ms_i   (s.dwell),
    .run_o  (),
    .done_o (dwell_done)
  );

  ms_timer #(
    .W (16)
  ) u_clear (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_i (s.tick),
    .load_i (clr_load),
    .ms_i   (s.clrw),
    .run_o  (clr_run),
    .done_o (clr_done)
  );

  assign wb_rsp_o.ack = s.ack;
  assign wb_rsp_o.dat = s.dat;
  assign pulse_o = ramp_pulse;
  assign dir_o = s.cfg[CFG_DIR];
  assign clear_o = clr_run;
  assign torque_limit_o = s.torque;
endmodule : origin_return_sequencer

// *** include/origin_pkg.sv ***
// constants and types shared by the origin-return sequencer files
package origin_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_TIME_NS  = 1000000;
  localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int ACCEL_SHIFT   = 12;

  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_CFG       = 8'h04;
  localparam logic [7:0] OFS_FAST      = 8'h08;
  localparam logic [7:0] OFS_CREEP     = 8'h0c;
  localparam logic [7:0] OFS_DWELL     = 8'h10;
  localparam logic [7:0] OFS_CLRW      = 8'h14;
  localparam logic [7:0] OFS_ORIGIN    = 8'h18;
  localparam logic [7:0] OFS_STATUS    = 8'h1c;
  localparam logic [7:0] OFS_ERROR     = 8'h20;
  localparam logic [7:0] OFS_CUR_FEED  = 8'h24;
  localparam logic [7:0] OFS_MACH_FEED = 8'h28;
  localparam logic [7:0] OFS_ACCEL     = 8'h2c;

  localparam int CTRL_START   = 0;
  localparam int CTRL_STOP    = 1;
  localparam int CTRL_RESTART = 2;
  localparam int CTRL_ERR_CLR = 3;

  localparam int CFG_METHOD   = 0;
  localparam int CFG_DIR      = 1;
  localparam int CFG_RETRY    = 2;
  localparam int CFG_ACCEL_LO = 4;

  localparam int STAT_BUSY     = 0;
  localparam int STAT_ERROR    = 1;
  localparam int STAT_REQUEST  = 3;
  localparam int STAT_COMPLETE = 4;

  localparam logic [15:0] ERR_NONE        = 16'h0000;
  localparam logic [15:0] ERR_START_AT_OP = 16'h00c9;
  localparam logic [15:0] ERR_DOG_TIMING  = 16'h00cb;
  localparam logic [15:0] ERR_DWELL_FAULT = 16'h00cd;
  localparam logic [15:0] ERR_NO_RESTART  = 16'h00d1;
  localparam logic [15:0] ERR_LIMIT       = 16'h00fe;

  localparam logic [7:0]  RST_CFG    = 8'h00;
  localparam logic [31:0] RST_FAST   = 32'h0040_0000;
  localparam logic [31:0] RST_CREEP  = 32'h0004_0000;
  localparam logic [15:0] RST_DWELL  = 16'h0064;
  localparam logic [15:0] RST_CLRW   = 16'h000a;
  localparam logic [31:0] RST_ACCEL  = 32'h4020_1008;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_type;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FAST,
    ST_DECEL,
    ST_CREEP,
    ST_SEEK_ZERO,
    ST_HALT,
    ST_CLEAR
  } seq_state_type;
endpackage : origin_pkg

// *** hdl/ms_timer.sv ***
// millisecond down-counter with a running level and a done pulse
`timescale 1ns/10ps
module ms_timer #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         tick_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] ms_i,
  output logic              run_o,
  output logic              done_o
);
  typedef struct packed {
    logic [W-1:0] count;
    logic         run;
    logic         done;
  } tmr_type;

  tmr_type s;
  tmr_type next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (load_i) begin
      next_s.count = ms_i;
      next_s.run = (ms_i != '0);
      next_s.done = (ms_i == '0);
    end else if (s.run && tick_i) begin
      if (s.count <= W'(1)) begin
        next_s.run = 1'b0;
        next_s.done = 1'b1;
      end else begin
        next_s.count = s.count - W'(1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign run_o = s.run;
  assign done_o = s.done;
endmodule : ms_timer

// *** hdl/speed_ramp.sv ***
// linear speed ramp driving a phase accumulator pulse generator
`timescale 1ns/10ps
module speed_ramp #(
  parameter int W = 32
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         tick_i,
  input  wire logic         halt_i,
  input  wire logic [W-1:0] target_i,
  input  wire logic [W-1:0] step_i,
  output logic [W-1:0]      speed_o,
  output logic              at_target_o,
  output logic              pulse_o
);
  typedef struct packed {
    logic [W-1:0] speed;
    logic [W-1:0] acc;
    logic         pulse;
  } ramp_type;

  ramp_type s;
  ramp_type next_s;

  always_comb begin
    logic [W:0] sum;
    sum = {1'b0, s.acc} + {1'b0, s.speed};
    next_s = s;
    next_s.acc = sum[W-1:0];
    next_s.pulse = sum[W];
    if (halt_i) begin
      next_s.speed = '0;
      next_s.acc = '0;
      next_s.pulse = 1'b0;
    end else if (tick_i) begin
      if (s.speed < target_i) begin
        if (target_i - s.speed > step_i) begin
          next_s.speed = s.speed + step_i;
        end else begin
          next_s.speed = target_i;
        end
      end else if (s.speed > target_i) begin
        if (s.speed - target_i > step_i) begin
          next_s.speed = s.speed - step_i;
        end else begin
          next_s.speed = target_i;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign speed_o = s.speed;
  assign at_target_o = (s.speed == target_i);
  assign pulse_o = s.pulse;
endmodule : speed_ramp

// *** tb/origin_drive_model.sv ***
// servo drive and axis sensor model: counts pulses, makes dog and zero
`timescale 1ns/10ps
module origin_drive_model (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               pulse_i,
  input  wire logic               dir_i,
  input  wire logic signed [31:0] dog_lo_i,
  input  wire logic signed [31:0] dog_hi_i,
  output logic                    dog_o,
  output logic                    zero_o,
  output logic signed [31:0]      pos_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_o  <= '0;
      zero_o <= 1'b0;
    end else begin
      if (pulse_i)
        pos_o <= dir_i ? pos_o - 1 : pos_o + 1;
      zero_o <= pulse_i && !dir_i && pos_o[2:0] == 3'h7;
    end
  end
  assign dog_o = pos_o >= dog_lo_i && pos_o < dog_hi_i;
endmodule : origin_drive_model

// *** tb/origin_return_sequencer_chk.sv ***
// concurrent checks on the origin-return sequencer ports
`timescale 1ns/10ps
module origin_return_sequencer_chk
  import origin_pkg::*;
#(
  parameter int TICK_CYCLES = 10
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire wb_req_type wb_req_i,
  input wire wb_rsp_type wb_rsp_o,
  input wire logic       dog_i,
  input wire logic       pulse_o,
  input wire logic       dir_o,
  input wire logic       clear_o,
  input wire logic       torque_limit_o
);
  logic        method;
  logic        dir_cfg;
  logic        rd_status;
  logic [15:0] clr_width;
  int          clr_cnt;
  logic        wr_done;
  assign wr_done = wb_req_i.cyc && wb_req_i.we && wb_rsp_o.ack;
  // shadow of the settings that the checks depend on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      method    <= RST_CFG[CFG_METHOD];
      dir_cfg   <= RST_CFG[CFG_DIR];
      clr_width <= RST_CLRW;
      clr_cnt   <= 0;
      rd_status <= 1'b0;
    end else begin
      if (wr_done && wb_req_i.adr == OFS_CFG && wb_req_i.sel[0])
        {dir_cfg, method} <= wb_req_i.dat[1:0];
      if (wr_done && wb_req_i.adr == OFS_CLRW && wb_req_i.sel[1:0] == 2'h3)
        clr_width <= wb_req_i.dat[15:0];
      clr_cnt <= clear_o ? clr_cnt + 1 : 0;
      if (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack)
        rd_status <= !wb_req_i.we && wb_req_i.adr == OFS_STATUS;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_taken;
    wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  endsequence
  sequence s_answer;
    wb_rsp_o.ack ##1 !wb_rsp_o.ack;
  endsequence
  property p_ack; s_taken |=> s_answer; endproperty
  property p_quiet; !(wb_req_i.cyc && wb_req_i.stb) |=> !wb_rsp_o.ack;
  endproperty
  property p_clear_still; clear_o |-> !pulse_o; endproperty
  property p_dog_off; $rose(clear_o) && !method |-> !dog_i; endproperty
  property p_width;
    clear_o |-> clr_cnt < int'(clr_width) * TICK_CYCLES;
  endproperty
  property p_flags;
    wb_rsp_o.ack && rd_status
      |-> !(wb_rsp_o.dat[STAT_COMPLETE] && wb_rsp_o.dat[STAT_REQUEST]);
  endproperty
  property p_torque; torque_limit_o |-> method; endproperty
  property p_dir; pulse_o |-> dir_o == dir_cfg; endproperty
  a_ack: assert property (p_ack) else $error("bus answer late or long");
  a_quiet: assert property (p_quiet) else $error("ack without request");
  a_clear_still: assert property (p_clear_still)
    else $error("pulse during clear");
  a_dog_off: assert property (p_dog_off)
    else $error("clear while dog on");
  a_width: assert property (p_width)
    else $error("clear output too long");
  a_flags: assert property (p_flags)
    else $error("complete and request both set");
  a_torque: assert property (p_torque)
    else $error("torque limit in dog method");
  a_dir: assert property (p_dir)
    else $error("direction differs from setting");
endmodule : origin_return_sequencer_chk

bind origin_return_sequencer origin_return_sequencer_chk #(
  .TICK_CYCLES(TICK_CYCLES)
) chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
  .dog_i(dog_i), .pulse_o(pulse_o), .dir_o(dir_o), .clear_o(clear_o),
  .torque_limit_o(torque_limit_o)
);

// *** tb/tb.sv ***
// self-checking bench for the origin-return sequencer
`timescale 1ns/10ps
module tb;
  import origin_pkg::*;
  localparam int LIMIT = 100000;
  logic               clk_i;
  logic               rst_i;
  logic               stop_i;
  logic               dog;
  logic               zero;
  logic               pulse;
  logic               dir;
  logic               clear;
  logic               torque;
  logic               torq_seen;
  wb_req_type         wb_req;
  wb_rsp_type         wb_rsp;
  logic signed [31:0] pos;
  logic signed [31:0] dog_lo;
  logic signed [31:0] dog_hi;
  logic [31:0]        rd;
  int n_fail, n_tests, cyc, gap, min_gap, last_gap, clr_len;

  origin_return_sequencer #(.TICK_CYCLES(10)) origin_return_sequencer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
    .dog_i(dog), .zero_i(zero), .stop_i(stop_i), .limit_upper_i(1'b0),
    .limit_lower_i(1'b0), .pulse_o(pulse), .dir_o(dir), .clear_o(clear),
    .torque_limit_o(torque));
  origin_drive_model origin_drive_model_inst (
    .clk_i(clk_i), .rst_i(rst_i), .pulse_i(pulse), .dir_i(dir),
    .dog_lo_i(dog_lo), .dog_hi_i(dog_hi), .dog_o(dog), .zero_o(zero),
    .pos_o(pos));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // pulse spacing, clear length and torque watch
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (pulse === 1'b1) begin
      min_gap <= (gap < min_gap) ? gap : min_gap;
      last_gap <= gap;
      gap <= 0;
    end else
      gap <= gap + 1;
    if (clear === 1'b1)
      clr_len <= clr_len + 1;
    // note whether the torque limit was requested
    if (torque === 1'b1)
      torq_seen <= 1'b1;
    if (cyc == LIMIT) begin
      n_fail++;
      tally_and_finish;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    wb_req <= '{1'b1, 1'b1, we, a, 4'hf, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_rsp.ack !== 1'b1);
    q = wb_rsp.dat;
    // ack one cycle after the request is taken
    check(n, 32'd2);
    wb_req <= '0;
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, rd);
  endtask : wr

  // one return with the dog band at pos+lo up to pos+hi, upper end excluded; ends reading the code
  task automatic run(input logic [31:0] cfg, input logic [31:0] dwell,
                     input int lo, input int hi, input int stop_at);
    int n;
    wr(OFS_CFG, cfg);
    wr(OFS_DWELL, dwell);
    dog_lo <= pos + lo;
    dog_hi <= pos + hi;
    min_gap = 1 << 20;
    clr_len = 0;
    torq_seen = 1'b0;
    wr(OFS_CTRL, 32'h1);
    if (stop_at > 0) begin
      repeat (stop_at) @(posedge clk_i);
      stop_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      stop_i <= 1'b0;
    end
    n = 0;
    do begin
      wb(1'b0, OFS_STATUS, 32'h0, rd);
      n++;
    end while (rd[STAT_BUSY] !== 1'b0 && n < 4000);
    check(32'(n < 4000), 32'h1);
    wb(1'b0, OFS_ERROR, 32'h0, rd);
  endtask : run

  task automatic sc_stop;
    run(32'h2, 32'd100, 1000, 1100, 800);
    check({31'h0, dir}, 32'h1);
    check(32'(pos < dog_lo - 1000), 32'h1);
    wr(OFS_CTRL, 32'h4);
    wb(1'b0, OFS_ERROR, 32'h0, rd);
    check(rd, 32'hd1);
    wr(OFS_CTRL, 32'h8);
  endtask : sc_stop

  task automatic sc_dog_early;
    run(32'h0, 32'd100, 40, 45, 0);
    check(rd, 32'hcb);
    wb(1'b0, OFS_STATUS, 32'h0, rd);
    check({30'h0, rd[STAT_COMPLETE:STAT_REQUEST]}, 32'h1);
    wr(OFS_CTRL, 32'h8);
  endtask : sc_dog_early

  task automatic sc_dog_method;
    run(32'h0, 32'd100, 40, 80, 0);
    check(rd, 32'h0);
    check(32'(min_gap <= 32), 32'h1);
    check(32'(last_gap >= 255), 32'h1);
    check(32'(clr_len > 20 && clr_len <= 30), 32'h1);
    wb(1'b0, OFS_STATUS, 32'h0, rd);
    check({30'h0, rd[STAT_COMPLETE:STAT_REQUEST]}, 32'h2);
    wb(1'b0, OFS_CUR_FEED, 32'h0, rd);
    check(rd, 32'h1234);
    wb(1'b0, OFS_MACH_FEED, 32'h0, rd);
    check(rd, 32'h1234);
    run(32'h0, 32'd100, 40, 80, 0);
    check(rd, 32'hc9);
    wr(OFS_CTRL, 32'h8);
  endtask : sc_dog_method

  task automatic sc_stopper;
    run(32'h1, 32'd150, 40, 400, 0);
    check(rd, 32'h0);
    check(32'(clr_len > 20 && clr_len <= 30), 32'h1);
    check({31'h0, torq_seen}, 32'h1);
    run(32'h1, 32'd50, 40, 400, 0);
    check(rd, 32'hcd);
    wr(OFS_CTRL, 32'h8);
  endtask : sc_stopper

  task automatic sc_dog_at_start;
    run(32'h4, 32'd100, -2, 6, 0);
    check(rd, 32'h0);
    check(32'(min_gap >= 255), 32'h1);
  endtask : sc_dog_at_start

  initial begin
    rst_i = 1'b1;
    stop_i = 1'b0;
    wb_req = '0;
    dog_lo = 0;
    dog_hi = 0;
    {n_fail, n_tests, cyc, gap, last_gap, clr_len} = '0;
    min_gap = 0;
    torq_seen = 1'b0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, OFS_STATUS, 32'h0, rd);
    check({30'h0, rd[STAT_COMPLETE:STAT_REQUEST]}, 32'h1);
    wb(1'b0, 8'h40, 32'h0, rd);
    check(rd, 32'h0);
    wr(OFS_FAST, 32'h0800_0000);
    wr(OFS_CREEP, 32'h0100_0000);
    wr(OFS_ACCEL, 32'h0000_00ff);
    wr(OFS_CLRW, 32'h3);
    wr(OFS_ORIGIN, 32'h1234);
    sc_stop;
    sc_dog_early;
    sc_dog_method;
    sc_stopper;
    sc_dog_at_start;
    tally_and_finish;
  end
endmodule : tb
